//--- verilog/dpram_pkg.sv
// constants, types and register map of the synchronous dual-port ram port logic
package dpram_pkg;

	// array geometry: 16k words of two 9-bit byte lanes
	localparam int ADDR_W = 14;
	localparam int DATA_W = 18;
	localparam int LANE_W = 9;
	localparam int NPORTS = 2;

	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [DATA_W-1:0] data_t;

	// one port's synchronous pins as the host drives them
	typedef struct packed {
		addr_t addr;
		data_t dataIn;
		logic  readWriteN;
		logic  selectLowN;
		logic  selectHigh;
		logic  addressLoadN;
		logic  counterAdvanceN;
		logic  counterClearN;
		logic  upperByteN;
		logic  lowerByteN;
	} portIn_s;

	// apb register map (byte addresses)
	localparam logic [11:0] CTRL_OFF      = 12'h000;
	localparam logic [11:0] CNT_LEFT_OFF  = 12'h004;
	localparam logic [11:0] CNT_RIGHT_OFF = 12'h008;

	// control register: one output-mode bit per port, 1 = pipelined
	localparam int          PIPE_LEFT_BIT  = 0;
	localparam int          PIPE_RIGHT_BIT = 1;
	localparam logic [1:0]  CTRL_RST       = 2'h0;
	localparam logic [13:0] CNT_RST        = 14'h0000;
	localparam logic [13:0] CNT_CLEAR_VAL  = 14'h0000;

	// cross-port timing, in ns, and the host-side wait in clk cycles
	localparam int CLK_PERIOD_NS             = 50;
	localparam int WRITE_TO_READ_DELAY_NS    = 30;
	localparam int CLOCK_SEPARATION_LIMIT_NS = 9;
	localparam int FLOW_CLOCK_TO_DATA_NS     = 15;
	localparam int WRITE_TO_READ_DELAY_CYC   =
		(WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- verilog/dpram_mem.sv
// two-port 16k x 18 storage array with byte-lane writes and registered reads
`timescale 1ns/10ps
`default_nettype none
module dpram_mem
	import dpram_pkg::*;
(
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rstn,
	// write side, one per port
	input  wire logic [NPORTS-1:0]          wrEn,
	input  wire logic [NPORTS-1:0][1:0]     laneEn,
	input  wire dpram_pkg::addr_t           wrAddr [NPORTS],
	input  wire dpram_pkg::data_t           wrData [NPORTS],
	// read side, one per port
	input  wire logic [NPORTS-1:0]          rdEn,
	input  wire dpram_pkg::addr_t           rdAddr [NPORTS],
	output dpram_pkg::data_t                rdData_ff [NPORTS]
);
	data_t mem [0:(1<<ADDR_W)-1];

	// byte-lane writes; two ports writing one lane of one word in one cycle leave the right port's data there
	always_ff @(posedge clk) begin
		for (int p = 0; p < NPORTS; p++) begin
			if (wrEn[p] && laneEn[p][0]) begin
				mem[wrAddr[p]][LANE_W-1:0] <= wrData[p][LANE_W-1:0];
			end
			if (wrEn[p] && laneEn[p][1]) begin
				mem[wrAddr[p]][DATA_W-1:LANE_W] <= wrData[p][DATA_W-1:LANE_W];
			end
		end
	end

	// read returns the word before any write in the same edge, the same for both ports
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int p = 0; p < NPORTS; p++) begin
				rdData_ff[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NPORTS; p++) begin
				if (rdEn[p]) begin
					rdData_ff[p] <= mem[rdAddr[p]];
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/dpram_port.sv
// port control of a synchronous dual-port ram: burst counters, output timing, apb control
`timescale 1ns/10ps
`default_nettype none
module dpram_port
	import dpram_pkg::*;
(
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// apb slave
	input  wire logic [11:0]            paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// ram ports, index 0 left, 1 right
	input  wire dpram_pkg::portIn_s     portIn [NPORTS],
	input  wire logic [NPORTS-1:0]      outputEnableN,
	output dpram_pkg::data_t            dataOut [NPORTS],
	output logic [NPORTS-1:0]           dataOeN
);
	import dpram_pkg::*;

	logic [1:0]        pipeMode_ff;
	addr_t             cnt_ff      [NPORTS];
	addr_t             nxt_cnt     [NPORTS];
	addr_t             rdAddrDly_ff[NPORTS];
	addr_t             memRdAddr   [NPORTS];
	addr_t             wrAddr      [NPORTS];
	data_t             wrData      [NPORTS];
	data_t             rdData      [NPORTS];
	logic [NPORTS-1:0] selected;
	logic [NPORTS-1:0] readReq;
	logic [NPORTS-1:0] writeReq;
	logic [NPORTS-1:0] readDly_ff;
	logic [NPORTS-1:0] memRdEn;
	logic [NPORTS-1:0] driveN_ff;
	logic [NPORTS-1:0][1:0] laneEn;
	logic [31:0]       prdata_ff;
	logic              pready_ff;
	logic              pslverr_ff;

	// next counter value: clear beats load beats advance
	function automatic addr_t nextCount(input portIn_s pin, input addr_t cur);
		if (!pin.counterClearN) begin
			return CNT_CLEAR_VAL;
		end else if (!pin.addressLoadN) begin
			return pin.addr;
		end else if (!pin.counterAdvanceN) begin
			return addr_t'(cur + 1'b1);
		end
		return cur;
	endfunction

	// port decode; the access address is the counter's new value, so load shows
	// the external address and clear shows zero in that same cycle
	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			selected[p] = !portIn[p].selectLowN && portIn[p].selectHigh;
			readReq[p]  = selected[p] && portIn[p].readWriteN;
			writeReq[p] = selected[p] && !portIn[p].readWriteN;
			nxt_cnt[p]  = nextCount(portIn[p], cnt_ff[p]);
			wrAddr[p]   = nxt_cnt[p];
			wrData[p]   = portIn[p].dataIn;
			laneEn[p]   = {!portIn[p].upperByteN, !portIn[p].lowerByteN};
			// pipelined reads go to the array one edge late, giving the extra clock
			memRdEn[p]   = pipeMode_ff[p] ? readDly_ff[p] : readReq[p];
			memRdAddr[p] = pipeMode_ff[p] ? rdAddrDly_ff[p] : nxt_cnt[p];
		end
	end

	// burst counters run with the port deselected too
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int p = 0; p < NPORTS; p++) begin
				cnt_ff[p] <= CNT_RST;
			end
		end else begin
			for (int p = 0; p < NPORTS; p++) begin
				cnt_ff[p] <= nxt_cnt[p];
			end
		end
	end

	// one-stage delay of the read request for pipelined ports
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			readDly_ff <= '0;
			for (int p = 0; p < NPORTS; p++) begin
				rdAddrDly_ff[p] <= CNT_RST;
			end
		end else begin
			readDly_ff <= readReq;
			for (int p = 0; p < NPORTS; p++) begin
				rdAddrDly_ff[p] <= nxt_cnt[p];
			end
		end
	end

	// drive state is settled at an edge from the controls then taken, so a
	// deselect floats the pins only after that edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			driveN_ff <= '1;
		end else begin
			driveN_ff <= ~memRdEn;
		end
	end

	dpram_mem u_mem (
		.clk       (clk),
		.rstn      (rstn),
		.wrEn      (writeReq),
		.laneEn    (laneEn),
		.wrAddr    (wrAddr),
		.wrData    (wrData),
		.rdEn      (memRdEn),
		.rdAddr    (memRdAddr),
		.rdData_ff (rdData)
	);

	// data comes from the array's output register; output enable bypasses the
	// clock on purpose, the one output not taken straight from a flop
	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			dataOut[p] = rdData[p];
		end
	end
	assign dataOeN = driveN_ff | outputEnableN;

	// apb: no wait state, pready raised for the access phase only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end else begin
			pready_ff  <= psel && !penable && !pready_ff;
			pslverr_ff <= 1'b0;
			if (psel && !penable) begin
				prdata_ff <= '0;
				case (paddr)
					CTRL_OFF: begin
						prdata_ff <= {30'h0, pipeMode_ff};
					end
					CNT_LEFT_OFF: begin
						prdata_ff <= {18'h0, cnt_ff[0]};
					end
					CNT_RIGHT_OFF: begin
						prdata_ff <= {18'h0, cnt_ff[1]};
					end
					default: begin
						pslverr_ff <= 1'b1;
					end
				endcase
			end
		end
	end

	// mode register written at the completing edge; counters are read only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pipeMode_ff <= CTRL_RST;
		end else if (psel && penable && pready_ff && pwrite && paddr == CTRL_OFF) begin
			pipeMode_ff <= {pwdata[PIPE_RIGHT_BIT], pwdata[PIPE_LEFT_BIT]};
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;

	// checks per port
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	for (genvar g = 0; g < NPORTS; g++) begin : gChk
		sequence flowRead;
			!pipeMode_ff[g] && readReq[g];
		endsequence
		sequence pipeRead;
			pipeMode_ff[g] && readReq[g] ##1 pipeMode_ff[g];
		endsequence

		counter_clear_a: assert property (!portIn[g].counterClearN |=> cnt_ff[g] == '0)
			else $error("counter not cleared");
		counter_inc_a: assert property (portIn[g].counterClearN && portIn[g].addressLoadN
			&& !portIn[g].counterAdvanceN |=> cnt_ff[g] == addr_t'($past(cnt_ff[g]) + 1'b1))
			else $error("counter did not advance by one");
		counter_hold_a: assert property (portIn[g].counterClearN && portIn[g].addressLoadN
			&& portIn[g].counterAdvanceN && !selected[g] |=> $stable(cnt_ff[g]))
			else $error("counter moved while held");
		addr_load_a: assert property (portIn[g].counterClearN && !portIn[g].addressLoadN
			|=> cnt_ff[g] == $past(portIn[g].addr))
			else $error("external address not taken");
		// expected address written out from the pins, not from the counter function
		addr_mux_a: assert property (portIn[g].counterClearN |-> wrAddr[g] ==
			(!portIn[g].addressLoadN ? portIn[g].addr
			: (portIn[g].counterAdvanceN ? cnt_ff[g] : addr_t'(cnt_ff[g] + 1'b1))))
			else $error("access address mismatch");
		deselect_float_a: assert property (!selected[g] && !pipeMode_ff[g]
			|-> ##1 driveN_ff[g])
			else $error("pins driven after deselect");
		flow_drive_a: assert property (flowRead |=> !driveN_ff[g])
			else $error("flow read not driven");
		pipe_late_a: assert property (pipeRead |=> !driveN_ff[g])
			else $error("pipelined read not one clock later");
		// a lone pipelined read must leave the flow-through slot undriven
		pipe_gap_a: assert property (pipeMode_ff[g] && readReq[g] && !readDly_ff[g]
			|=> driveN_ff[g])
			else $error("pipelined read driven a clock early");
		oe_async_a: assert property (outputEnableN[g] |-> dataOeN[g])
			else $error("output enable ignored");
	end
endmodule
`default_nettype wire

//--- test/host_model.sv
// host controllers on both ram ports: drive the synchronous pins once per clock
`timescale 1ns/10ps
`default_nettype none
module host_model
	import dpram_pkg::*;
(
	// clock
	input  wire logic              clk,
	// synchronous pins, index 0 left, 1 right
	output var dpram_pkg::portIn_s pins [NPORTS]
);
	// deselected, counter held; addr and data inverted so stale values never match
	function automatic portIn_s idle(input portIn_s last);
		idle = '{~last.addr, ~last.dataIn, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
	endfunction
	// new pins land just after an edge, so the design takes them at the next one
	task put(input portIn_s l, input portIn_s r);
		@(posedge clk);
		pins[0] <= l;
		pins[1] <= r;
	endtask
	// never a selected no-op cycle, so no word is owed a rewrite
	initial begin
		pins[0] = idle('0);
		pins[1] = idle('0);
	end
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the dual-port ram port control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import dpram_pkg::*;
	// clock, reset and apb
	logic              clk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata;
	// ram port pins
	portIn_s           pins [NPORTS];
	logic [NPORTS-1:0] outputEnableN, dataOeN;
	data_t             dataOut [NPORTS];
	// bookkeeping
	int                numErrors = 0, nTests = 0, cycles = 0;
	data_t             m1, m2;
	portIn_s           v;

	dpram_port dpram_port_i (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .portIn(pins),
		.outputEnableN(outputEnableN), .dataOut(dataOut), .dataOeN(dataOeN));
	host_model host_model_i (.clk(clk), .pins(pins));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// hang guard: the sequence needs under a hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			numErrors++;
			$display("mismatch at %0t: run hung", $time);
			results();
		end
	end
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			numErrors++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// apb transfer, held until pready is seen at an edge
	task regAcc(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] x, input logic xe);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		chk({31'b0, pready}, 32'h1);
		if (!wr)
			chk(prdata, x);
		chk({31'b0, pslverr}, {31'b0, xe});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// selected access with the external address loaded
	function automatic portIn_s acc(logic rw, addr_t a, data_t d, logic [1:0] lnN);
		acc = '{a, d, rw, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, lnN[1], lnN[0]};
	endfunction
	function automatic portIn_s id(int p);
		id = host_model_i.idle(pins[p]);
	endfunction
	// drive port p, idle the other, settle past the edge taking the previous pins
	task drv(input int p, input portIn_s s);
		portIn_s q [NPORTS];
		q[p] = s;
		q[1-p] = id(1 - p);
		host_model_i.put(q[0], q[1]);
		#1;
	endtask
	// drive state, and data only where driven
	task see(input int p, input data_t d, input logic oeN);
		chk({31'b0, dataOeN[p]}, {31'b0, oeN});
		if (oeN === 1'b0)
			chk({14'b0, dataOut[p]}, {14'b0, d});
	endtask
	// counts and verdict
	task results();
		$display("checks %0d, mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		m1 = (18'h2a5a5 & 18'h3fe00) | (18'h0ff0f & 18'h001ff);
		m2 = (18'h3c3c3 & 18'h3fe00) | (18'h15a5a & 18'h001ff);
		rstn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		outputEnableN = '0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		// reset values, refused word, mode bits
		regAcc(1'b0, CTRL_OFF, '0, 32'(CTRL_RST), 1'b0);
		regAcc(1'b1, CNT_RIGHT_OFF, 32'h1234, '0, 1'b0);
		regAcc(1'b0, CNT_RIGHT_OFF, '0, 32'(CNT_RST), 1'b0);
		regAcc(1'b1, 12'h00c, 32'h3, '0, 1'b1);
		regAcc(1'b0, 12'h00c, '0, '0, 1'b1);
		regAcc(1'b1, CTRL_OFF, 32'h3, '0, 1'b0);
		regAcc(1'b0, CTRL_OFF, '0, 32'h3, 1'b0);
		regAcc(1'b1, CTRL_OFF, '0, '0, 1'b0);
		// scattered writes with one lane masked, then back-to-back flow reads
		drv(0, acc(1'b0, 14'h0123, 18'h2a5a5, 2'b00));
		drv(0, acc(1'b0, 14'h3f00, 18'h15a5a, 2'b00));
		drv(0, acc(1'b0, 14'h0123, 18'h0ff0f, 2'b10));
		see(0, '0, 1'b1);
		drv(0, acc(1'b0, 14'h3f00, 18'h3c3c3, 2'b01));
		drv(0, acc(1'b1, 14'h0123, '0, 2'b00));
		drv(0, acc(1'b1, 14'h3f00, '0, 2'b00));
		see(0, m1, 1'b0);
		drv(0, id(0));
		see(0, m2, 1'b0);
		drv(0, id(0));
		see(0, '0, 1'b1);
		// output enable raised at the read's edge wins at once
		drv(0, acc(1'b1, 14'h0123, '0, 2'b00));
		host_model_i.put(id(0), id(1));
		outputEnableN <= 2'b01;
		#1;
		see(0, '0, 1'b1);
		chk({14'b0, dataOut[0]}, {14'b0, m1});
		host_model_i.put(id(0), id(1));
		outputEnableN <= 2'b00;
		// write on one port, read it on the other after the write-to-read wait
		for (int p = 0; p < 2; p++) begin
			drv(p, acc(1'b0, 14'h0777 + 14'(p), 18'h1e1e1 ^ 18'(p), 2'b00));
			repeat (WRITE_TO_READ_DELAY_CYC - 1) drv(p, id(p));
			drv(1 - p, acc(1'b1, 14'h0777 + 14'(p), '0, 2'b00));
			drv(p, id(p));
			see(1 - p, 18'h1e1e1 ^ 18'(p), 1'b0);
		end
		// counter load, advance and hold while deselected
		v = id(0);
		v.addressLoadN = 1'b0;
		v.addr = 14'h3eff;
		drv(0, v);
		v.addressLoadN = 1'b1;
		v.counterAdvanceN = 1'b0;
		repeat (3) drv(0, v);
		drv(0, id(0));
		regAcc(1'b0, CNT_LEFT_OFF, '0, 32'h3f02, 1'b0);
		// read addressed by the advancing counter, external address ignored
		v.counterAdvanceN = 1'b1;
		v.addressLoadN = 1'b0;
		drv(0, v);
		v = acc(1'b1, 14'h0123, '0, 2'b00);
		v.addressLoadN = 1'b1;
		v.counterAdvanceN = 1'b0;
		drv(0, v);
		drv(0, id(0));
		see(0, m2, 1'b0);
		// clear overrides load and advance and shares its cycle with a read
		drv(0, acc(1'b0, 14'h0000, 18'h2bcde, 2'b00));
		v.counterClearN = 1'b0;
		v.addressLoadN = 1'b0;
		drv(0, v);
		drv(0, id(0));
		see(0, 18'h2bcde, 1'b0);
		regAcc(1'b0, CNT_LEFT_OFF, '0, 32'(CNT_CLEAR_VAL), 1'b0);
		// pipelined reads answer one edge later
		regAcc(1'b1, CTRL_OFF, 32'h3, '0, 1'b0);
		for (int p = 0; p < 2; p++) begin
			drv(p, acc(1'b1, 14'h0777 + 14'(p), '0, 2'b00));
			drv(p, id(p));
			see(p, '0, 1'b1);
			drv(p, id(p));
			see(p, 18'h1e1e1 ^ 18'(p), 1'b0);
			drv(p, id(p));
			see(p, '0, 1'b1);
		end
		results();
	end
endmodule
`default_nettype wire
